// >>> rtl/etl_edge_stamp_logger.sv
// Four-channel edge time stamp logger with shifting entry history
// Behaviour
// - Each cycle with one or more enabled edges captures input states, sequence number and timer as one four-byte entry.
// - The history is 5 entries (20 bytes) or 15 entries (60 bytes) by configured variant.
// - An entry holds levels at +0, sequence at +1, stamp at +2, and entry n starts at byte 4n.
// - Levels byte carries channels 0..3 in bits 0..3 and zeros in bits 4..7.
// - Stored levels are those after the triggering edge.
// - The sequence number counts 0..127 in edge order, the first entry carrying 1.
// - A 32-bit microsecond counter starts at zero on reset and wraps.
// - The stamp holds the low 16 bits of the microsecond counter.
// - No output-area bytes are used and output-area writes have no effect.
// - Each channel has a delay filter on both directions, settable from 2 us to 2731 us.
// - A new entry goes to byte 0, older ones move up four bytes, the oldest falls off.
`timescale 1ns/1ns
module etl_edge_stamp_logger #(
	parameter int CHANNELS    = etl_pkg::CHANNELS,
	parameter int MAX_ENTRIES = etl_pkg::LARGE_ENTRIES,
	parameter int TICK_CYCLES = etl_pkg::TICK_CYCLES
) (
	input  wire logic                    clock,
	input  wire logic                    resetn,
	input  wire logic [CHANNELS-1:0]     inputPins,
	input  wire etl_pkg::etl_cfg_wr_t    cfgWrite,
	input  wire etl_pkg::etl_read_req_t  readReq,
	output logic [7:0]                   readData,
	output logic                         readValid,
	output logic [CHANNELS-1:0]          inputLevels
);

	localparam int TW = etl_pkg::TIMER_BITS;
	localparam int SW = etl_pkg::SEQ_BITS;

	logic [15:0]               tickCnt_ff;
	logic                      usTick;
	logic [TW-1:0]             usCount_ff;
	logic [7:0]                delayCode_ff [CHANNELS];
	logic [CHANNELS-1:0]       riseEn_ff;
	logic [CHANNELS-1:0]       fallEn_ff;
	logic                      largeVariant_ff;
	logic [CHANNELS-1:0]       levels;
	logic [CHANNELS-1:0]       prevLevels_ff;
	logic [CHANNELS-1:0]       riseHit;
	logic [CHANNELS-1:0]       fallHit;
	logic                      edgeEvent;
	logic [SW-1:0]             seq_ff;
	logic [SW-1:0]             nxt_seq;
	logic [15:0]               stampNow;
	etl_pkg::etl_entry_t       hist_ff [MAX_ENTRIES];
	etl_pkg::etl_entry_t       newEntry;
	etl_pkg::etl_entry_t       selEntry;
	logic [etl_pkg::ADDR_BITS-1:0] imageLen;
	logic [7:0]                nxt_readData;
	logic [7:0]                readData_ff;
	logic                      readValid_ff;
	logic [CHANNELS-1:0]       levels_ff;

	// ==========================================================
	// Microsecond timer
	assign usTick = (tickCnt_ff == 16'(TICK_CYCLES - 1));

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			tickCnt_ff <= '0;
		else if (usTick)
			tickCnt_ff <= '0;
		else
			tickCnt_ff <= tickCnt_ff + 1'b1;
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			usCount_ff <= '0;
		else if (usTick)
			usCount_ff <= usCount_ff + 1'b1;
	end

	assign stampNow = usCount_ff[15:0];

	// ==========================================================
	// Parameter registers; output-area traffic has no port at all
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			riseEn_ff       <= etl_pkg::EDGE_RESET;
			fallEn_ff       <= etl_pkg::EDGE_RESET;
			largeVariant_ff <= etl_pkg::VARIANT_RESET;
			for (int i = 0; i < CHANNELS; i++)
				delayCode_ff[i] <= etl_pkg::DELAY_RESET;
		end
		else if (cfgWrite.en)
		begin
			case (cfgWrite.addr)
				etl_pkg::CFG_RISE:    riseEn_ff <= cfgWrite.data[CHANNELS-1:0];
				etl_pkg::CFG_FALL:    fallEn_ff <= cfgWrite.data[CHANNELS-1:0];
				etl_pkg::CFG_VARIANT: largeVariant_ff <= cfgWrite.data[0];
				default:
				begin
					if (cfgWrite.addr < 3'(CHANNELS))
						delayCode_ff[cfgWrite.addr[1:0]] <= cfgWrite.data;
				end
			endcase
		end
	end

	// ==========================================================
	// Input filters
	generate
		for (genvar g = 0; g < CHANNELS; g++)
		begin : g_chan
			etl_input_filter #(
				.DELAY_BITS(etl_pkg::DELAY_BITS)
			) u_filter (
				.clock   (clock),
				.resetn  (resetn),
				.rawPin  (inputPins[g]),
				.usTick  (usTick),
				.delayUs (etl_pkg::delay_us(delayCode_ff[g])),
				.level   (levels[g])
			);
		end
	endgenerate

	// ==========================================================
	// Edge detection and entry capture
	assign riseHit   = levels & ~prevLevels_ff & riseEn_ff;
	assign fallHit   = ~levels & prevLevels_ff & fallEn_ff;
	assign edgeEvent = |(riseHit | fallHit);
	assign nxt_seq   = seq_ff + 1'b1;
	assign newEntry  = '{levels: levels, seq: nxt_seq, stamp: stampNow};

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			prevLevels_ff <= '0;
			levels_ff     <= '0;
		end
		else
		begin
			prevLevels_ff <= levels;
			levels_ff     <= levels;
		end
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			seq_ff <= '0;
		else if (edgeEvent)
			seq_ff <= nxt_seq;
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			for (int i = 0; i < MAX_ENTRIES; i++)
				hist_ff[i] <= '0;
		end
		else if (edgeEvent)
		begin
			hist_ff[0] <= newEntry;
			for (int i = 1; i < MAX_ENTRIES; i++)
				hist_ff[i] <= hist_ff[i-1];
		end
	end

	// ==========================================================
	// Process image read port
	assign imageLen = largeVariant_ff ? 6'(etl_pkg::LARGE_ENTRIES * etl_pkg::ENTRY_BYTES)
	                                  : 6'(etl_pkg::SMALL_ENTRIES * etl_pkg::ENTRY_BYTES);

	always_comb
	begin
		selEntry     = hist_ff[readReq.addr[5:2]];
		nxt_readData = '0;
		if (readReq.addr < imageLen)
		begin
			case (readReq.addr[1:0])
				etl_pkg::OFS_LEVELS:   nxt_readData = {4'h0, selEntry.levels};
				etl_pkg::OFS_SEQ:      nxt_readData = {1'b0, selEntry.seq};
				etl_pkg::OFS_STAMP_HI: nxt_readData = selEntry.stamp[15:8];
				etl_pkg::OFS_STAMP_LO: nxt_readData = selEntry.stamp[7:0];
				default:               nxt_readData = '0;
			endcase
		end
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			readData_ff  <= '0;
			readValid_ff <= 1'b0;
		end
		else
		begin
			readValid_ff <= readReq.en;
			if (readReq.en)
				readData_ff <= nxt_readData;
		end
	end

	assign readData    = readData_ff;
	assign readValid   = readValid_ff;
	assign inputLevels = levels_ff;

	// ==========================================================
	// Checks
	property p_seq_step;
		@(posedge clock) disable iff (!resetn)
		edgeEvent |=> (seq_ff == SW'($past(seq_ff) + 1'b1));
	endproperty
	a_seq_step: assert property (p_seq_step) else $error("sequence did not step on entry");

	property p_seq_hold;
		@(posedge clock) disable iff (!resetn)
		!edgeEvent |=> $stable(seq_ff);
	endproperty
	a_seq_hold: assert property (p_seq_hold) else $error("sequence moved without entry");

	property p_head_entry;
		@(posedge clock) disable iff (!resetn)
		edgeEvent |=> (hist_ff[0].levels == $past(levels) && hist_ff[0].stamp == $past(stampNow)
			&& hist_ff[0].seq == seq_ff);
	endproperty
	a_head_entry: assert property (p_head_entry) else $error("new entry content wrong");

	property p_shift;
		@(posedge clock) disable iff (!resetn)
		edgeEvent |=> (hist_ff[1] == $past(hist_ff[0]));
	endproperty
	a_shift: assert property (p_shift) else $error("history did not shift");

	property p_no_edge_no_entry;
		@(posedge clock) disable iff (!resetn)
		(levels == prevLevels_ff) |=> $stable(hist_ff[0]);
	endproperty
	a_no_edge_no_entry: assert property (p_no_edge_no_entry) else $error("entry without edge");

	property p_timer_step;
		@(posedge clock) disable iff (!resetn)
		usTick |=> (usCount_ff == TW'($past(usCount_ff) + 1'b1)) ##1 !usTick [*2];
	endproperty
	a_timer_step: assert property (p_timer_step) else $error("microsecond timer step wrong");

	property p_beyond_image;
		@(posedge clock) disable iff (!resetn)
		(readReq.en && readReq.addr >= imageLen) |=> (readValid_ff && readData_ff == 8'h00);
	endproperty
	a_beyond_image: assert property (p_beyond_image) else $error("read past image not zero");

	property p_levels_upper;
		@(posedge clock) disable iff (!resetn)
		(readReq.en && readReq.addr[1:0] == etl_pkg::OFS_LEVELS) |=> (readData_ff[7:4] == 4'h0);
	endproperty
	a_levels_upper: assert property (p_levels_upper) else $error("levels upper nibble set");

endmodule : etl_edge_stamp_logger

// >>> rtl/etl_pkg.sv
// Constants, types and filter delay table shared by the edge time stamp logger
package etl_pkg;

	// ==========================================================
	// Sizes
	localparam int CHANNELS      = 4;
	localparam int SEQ_BITS      = 7;
	localparam int STAMP_BITS    = 16;
	localparam int TIMER_BITS    = 32;
	localparam int ENTRY_BYTES   = 4;
	localparam int SMALL_ENTRIES = 5;
	localparam int LARGE_ENTRIES = 15;
	localparam int ADDR_BITS     = 6;
	localparam int DELAY_BITS    = 12;

	// ==========================================================
	// Timing
	localparam int CLOCK_PERIOD_NS = 4;
	localparam int US_NS           = 1000;
	localparam int TICK_CYCLES     = (US_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

	// ==========================================================
	// Byte offsets inside one entry
	localparam logic [1:0] OFS_LEVELS   = 2'h0;
	localparam logic [1:0] OFS_SEQ      = 2'h1;
	localparam logic [1:0] OFS_STAMP_HI = 2'h2;
	localparam logic [1:0] OFS_STAMP_LO = 2'h3;

	// ==========================================================
	// Parameter write addresses and reset values
	localparam logic [2:0] CFG_DELAY0  = 3'h0;
	localparam logic [2:0] CFG_RISE    = 3'h4;
	localparam logic [2:0] CFG_FALL    = 3'h5;
	localparam logic [2:0] CFG_VARIANT = 3'h6;
	localparam logic [7:0] DELAY_RESET   = 8'h02;
	localparam logic [3:0] EDGE_RESET    = 4'h0;
	localparam logic       VARIANT_RESET = 1'b1;

	// ==========================================================
	// Filter delay codes and their times in microseconds
	localparam logic [7:0] DLY_CODE_2US    = 8'h00;
	localparam logic [7:0] DLY_CODE_4US    = 8'h02;
	localparam logic [7:0] DLY_CODE_12US   = 8'h04;
	localparam logic [7:0] DLY_CODE_86US   = 8'h07;
	localparam logic [7:0] DLY_CODE_342US  = 8'h09;
	localparam logic [7:0] DLY_CODE_2731US = 8'h0C;
	localparam logic [11:0] DLY_US_2    = 12'h002;
	localparam logic [11:0] DLY_US_4    = 12'h004;
	localparam logic [11:0] DLY_US_12   = 12'h00C;
	localparam logic [11:0] DLY_US_86   = 12'h056;
	localparam logic [11:0] DLY_US_342  = 12'h156;
	localparam logic [11:0] DLY_US_2731 = 12'hAAB;

	typedef struct packed {
		logic [CHANNELS-1:0]   levels;
		logic [SEQ_BITS-1:0]   seq;
		logic [STAMP_BITS-1:0] stamp;
	} etl_entry_t;

	typedef struct packed {
		logic                 en;
		logic [ADDR_BITS-1:0] addr;
	} etl_read_req_t;

	typedef struct packed {
		logic       en;
		logic [2:0] addr;
		logic [7:0] data;
	} etl_cfg_wr_t;

	// Impermissible codes fall back to the shortest delay
	function automatic logic [11:0] delay_us(input logic [7:0] code);
		case (code)
			DLY_CODE_2US:    delay_us = DLY_US_2;
			DLY_CODE_4US:    delay_us = DLY_US_4;
			DLY_CODE_12US:   delay_us = DLY_US_12;
			DLY_CODE_86US:   delay_us = DLY_US_86;
			DLY_CODE_342US:  delay_us = DLY_US_342;
			DLY_CODE_2731US: delay_us = DLY_US_2731;
			default:         delay_us = DLY_US_2;
		endcase
	endfunction : delay_us

endpackage : etl_pkg

// >>> rtl/etl_input_filter.sv
// One channel: pin synchroniser and symmetric input delay filter
`timescale 1ns/1ns
module etl_input_filter #(
	parameter int DELAY_BITS = etl_pkg::DELAY_BITS
) (
	input  wire logic                  clock,
	input  wire logic                  resetn,
	input  wire logic                  rawPin,
	input  wire logic                  usTick,
	input  wire logic [DELAY_BITS-1:0] delayUs,
	output logic                       level
);

	logic                  syncA_ff;
	logic                  syncB_ff;
	logic                  level_ff;
	logic [DELAY_BITS-1:0] count_ff;

	// ==========================================================
	// Synchroniser
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			syncA_ff <= 1'b0;
			syncB_ff <= 1'b0;
		end
		else
		begin
			syncA_ff <= rawPin;
			syncB_ff <= syncA_ff;
		end
	end

	// ==========================================================
	// Filter: a new level must stand for delayUs ticks, either direction
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			level_ff <= 1'b0;
			count_ff <= '0;
		end
		else if (syncB_ff == level_ff)
			count_ff <= '0;
		else if (usTick)
		begin
			if (count_ff + 1'b1 >= delayUs)
			begin
				level_ff <= syncB_ff;
				count_ff <= '0;
			end
			else
				count_ff <= count_ff + 1'b1;
		end
	end

	assign level = level_ff;

	property p_filter_change;
		@(posedge clock) disable iff (!resetn)
		(level_ff != $past(level_ff)) |-> ($past(usTick) && level_ff == $past(syncB_ff));
	endproperty
	a_filter_change: assert property (p_filter_change) else $error("filtered level moved without tick");

	property p_filter_short_glitch;
		@(posedge clock) disable iff (!resetn)
		(syncB_ff == level_ff) |=> (level_ff == $past(level_ff));
	endproperty
	a_filter_short_glitch: assert property (p_filter_short_glitch) else $error("level moved while input agreed");

endmodule : etl_input_filter

// >>> verif/etl_host_model.sv
// Host side model: parameter writes and process image byte reads
`timescale 1ns/1ns
module etl_host_model (
	input  wire logic             clock,
	output etl_pkg::etl_cfg_wr_t   cfgWrite,
	output etl_pkg::etl_read_req_t readReq,
	input  wire logic [7:0]        readData,
	input  wire logic              readValid
);
	initial
	begin
		cfgWrite = '0;
		readReq  = '0;
	end

	// ==========================================================
	// Parameter byte write, one strobe cycle
	task automatic write_param(input logic [2:0] addr, input logic [7:0] data);
		@(posedge clock);
		#1 cfgWrite = '{en: 1'b1, addr: addr, data: data};
		@(posedge clock);
		#1 cfgWrite.en = 1'b0;
	endtask : write_param

	// ==========================================================
	// Image byte read; callers read only while the inputs are quiet
	task automatic read_byte(input logic [5:0] addr, output logic [7:0] data, output logic valid);
		@(posedge clock);
		#1 readReq = '{en: 1'b1, addr: addr};
		@(posedge clock);
		#1 readReq.en = 1'b0;
		valid = readValid;
		data  = readData;
	endtask : read_byte
endmodule : etl_host_model

// >>> verif/edge_time_stamp_logger_tb.sv
// Self-checking bench for the edge time stamp logger
`timescale 1ns/1ns
module edge_time_stamp_logger_tb;
	localparam int TICKS = 4;
	logic                   clock;
	logic                   resetn;
	logic [3:0]             inputPins;
	etl_pkg::etl_cfg_wr_t   cfgWrite;
	etl_pkg::etl_read_req_t readReq;
	logic [7:0]             readData;
	logic                   readValid;
	logic [3:0]             inputLevels;
	int                     failures;
	int                     checks_done;
	int                     cycles;
	int                     edgeCycle;
	logic [6:0]             seqExp;

	etl_edge_stamp_logger #(.TICK_CYCLES(TICKS)) dut (
		.clock(clock), .resetn(resetn), .inputPins(inputPins), .cfgWrite(cfgWrite),
		.readReq(readReq), .readData(readData), .readValid(readValid), .inputLevels(inputLevels));
	etl_host_model host (
		.clock(clock), .cfgWrite(cfgWrite), .readReq(readReq), .readData(readData), .readValid(readValid));

	initial
	begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	always @(posedge clock)
	begin
		if (resetn)
			cycles++;
		if (cycles == 60000)
		begin
			failures++;
			results();
		end
	end

	// ==========================================================
	// Shared helpers
	task automatic results();
		if (failures == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : results

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic rd(input int addr, input logic [7:0] exp);
		logic [7:0] d;
		logic       v;
		host.read_byte(addr[5:0], d, v);
		check($sformatf("byte %0d", addr), {8'h01, exp}, {7'h0, v, d});
	endtask : rd

	task automatic chk_entry(input int n, input logic [3:0] lv, input logic [6:0] sq);
		rd(4 * n, {4'h0, lv});
		rd(4 * n + 1, {1'b0, sq});
	endtask : chk_entry

	task automatic edge_to(input logic [3:0] pins);
		int n;
		n = 0;
		@(posedge clock);
		#1 inputPins = pins;
		while (inputLevels !== pins && n < 60)
		begin
			@(posedge clock);
			#1 n++;
		end
		check("inputLevels", {12'h0, pins}, {12'h0, inputLevels});
		edgeCycle = cycles;
		@(posedge clock);
	endtask : edge_to

	task automatic pulse3(input int len);
		@(posedge clock);
		#1 inputPins[3] = 1'b1;
		repeat (len) @(posedge clock);
		#1 inputPins[3] = 1'b0;
		repeat (40) @(posedge clock);
	endtask : pulse3

	task automatic chk_stamp();
		logic [7:0] hi;
		logic [7:0] lo;
		logic       v;
		int         diff;
		host.read_byte(6'd2, hi, v);
		host.read_byte(6'd3, lo, v);
		diff = (edgeCycle / TICKS) % 65536 - int'({hi, lo});
		check("stamp window", 16'h0001, {15'h0, diff >= -3 && diff <= 3});
	endtask : chk_stamp

	// ==========================================================
	// Scenarios
	task automatic s_reset();
		check("inputLevels", 16'h0000, {12'h0, inputLevels});
		rd(0, 8'h00);
		rd(1, 8'h00);
		rd(59, 8'h00);
		for (int c = 0; c < 4; c++)
			host.write_param(c[2:0], 8'h00);
		host.write_param(3'h4, 8'h05);
		host.write_param(3'h5, 8'h02);
	endtask : s_reset

	task automatic s_capture();
		edge_to(4'b0010);
		chk_entry(0, 4'h0, 7'h00);
		edge_to(4'b0110);
		chk_entry(0, 4'b0110, 7'h01);
		chk_stamp();
		edge_to(4'b0101);
		chk_entry(0, 4'b0101, 7'h02);
		chk_entry(1, 4'b0110, 7'h01);
		chk_entry(2, 4'h0, 7'h00);
	endtask : s_capture

	task automatic s_filter();
		host.write_param(3'h4, 8'h0F);
		host.write_param(3'h5, 8'h0F);
		host.write_param(3'h3, 8'h04);
		pulse3(20);
		chk_entry(0, 4'b0101, 7'h02);
		host.write_param(3'h3, 8'h00);
		pulse3(20);
		chk_entry(0, 4'b0101, 7'h04);
		chk_entry(1, 4'b1101, 7'h03);
	endtask : s_filter

	task automatic s_wrap();
		seqExp = 7'h04;
		for (int i = 0; i < 130; i++)
		begin
			edge_to(inputPins ^ 4'b0001);
			seqExp = seqExp + 7'h01;
		end
		chk_entry(0, inputPins, seqExp);
		chk_entry(14, inputPins, seqExp - 7'd14);
		rd(60, 8'h00);
		host.write_param(3'h6, 8'h00);
		rd(20, 8'h00);
		rd(17, {1'b0, seqExp - 7'd4});
		host.write_param(3'h6, 8'h01);
		rd(57, {1'b0, seqExp - 7'd14});
	endtask : s_wrap

	// Channel 3 filter time for one delay code, rising then falling
	task automatic delay_to(input logic [7:0] code, input int us);
		int n;
		host.write_param(3'h3, code);
		for (int lv = 1; lv >= 0; lv--)
		begin
			n = 0;
			@(posedge clock);
			#1 inputPins[3] = lv[0];
			while (inputLevels[3] !== lv[0] && n < 3000 * TICKS)
			begin
				@(posedge clock);
				#1 n++;
			end
			check("filter cycles", 16'h0001, {15'h0, n >= us * TICKS && n < (us + 1) * TICKS});
		end
	endtask : delay_to

	task automatic s_delays();
		delay_to(8'h00, 2);
		delay_to(8'h02, 4);
		delay_to(8'h04, 12);
		delay_to(8'h07, 86);
		delay_to(8'h09, 342);
		delay_to(8'h0C, 2731);
		delay_to(8'h01, 2);
		chk_entry(0, 4'b0101, seqExp + 7'd14);
		chk_entry(1, 4'b1101, seqExp + 7'd13);
	endtask : s_delays

	initial
	begin
		resetn      = 1'b0;
		inputPins   = 4'h0;
		failures    = 0;
		checks_done = 0;
		cycles      = 0;
		edgeCycle   = 0;
		repeat (4) @(posedge clock);
		#1 resetn = 1'b1;
		s_reset();
		s_capture();
		s_filter();
		s_wrap();
		s_delays();
		results();
	end
endmodule : edge_time_stamp_logger_tb
